/* File: hdl/spdc_pkg.sv */
// Shared constants for the sync and power-down control bank and its serial link.
package spdc_pkg;
   localparam logic [7:0] SPDC_ADDR_SYNC_CTL  = 8'h58;
   localparam logic [7:0] SPDC_ADDR_SPARE     = 8'h59;
   localparam logic [7:0] SPDC_ADDR_XFER      = 8'h5a;
   localparam logic [7:0] SPDC_ADDR_PDN_CTL   = 8'h5b;
   localparam logic [7:0] SPDC_ADDR_DIV_BASE  = 8'h48;
   localparam logic [7:0] SPDC_ADDR_STATUS    = 8'h5c;
   localparam int         SPDC_NUM_OUT        = 8;
   localparam logic [7:0] SPDC_SYNC_CTL_RST   = 8'h00;
   localparam logic [7:0] SPDC_PDN_CTL_RST    = 8'h00;
   localparam logic [7:0] SPDC_DIV_RST        = 8'h00;
   localparam int         SPDC_BIT_DET_EN     = 0;
   localparam int         SPDC_BIT_DET_WIN    = 1;
   localparam int         SPDC_BIT_SOFT_SYNC  = 2;
   localparam int         SPDC_BIT_DIST_REF   = 3;
   localparam int         SPDC_BIT_SYNC_PD    = 4;
   localparam int         SPDC_BIT_PIN_LO     = 5;
   localparam int         SPDC_BIT_XFER       = 0;
   localparam int         SPDC_BIT_PLL_PD     = 0;
   localparam int         SPDC_BIT_DIST_PD    = 1;
   localparam int         SPDC_BIT_FD_A_SEL   = 2;
   localparam int         SPDC_BIT_FD_B_SEL   = 3;
   localparam int         SPDC_BIT_OUT_PD     = 4;
   localparam int         SPDC_BIT_OUT_OFF    = 5;
   localparam int         SPDC_BIT_NOSYNC     = 6;
   localparam int         SPDC_BIT_BYPASS     = 7;
   localparam int         SPDC_FD_A_IDX       = 5;
   localparam int         SPDC_FD_B_IDX       = 6;
   localparam int         SPDC_FRAME_BITS     = 17;
   localparam int         SPDC_SCLK_DIV       = 2;
   localparam logic [4:0] SPDC_BITCNT_ZERO    = 5'h00;
   typedef enum logic [1:0] {
      SPDC_PIN_RESET = 2'b00,
      SPDC_PIN_SYNC  = 2'b01,
      SPDC_PIN_TEST  = 2'b10,
      SPDC_PIN_PDN   = 2'b11
   } spdc_pin_mode_t;
   typedef enum logic [1:0] {
      SPDC_ST_IDLE  = 2'b00,
      SPDC_ST_SHIFT = 2'b01,
      SPDC_ST_DONE  = 2'b10
   } spdc_state_t;
endpackage : spdc_pkg

/* File: hdl/spdc_if.sv */
// Serial control link joining the host end and the device end.
`timescale 1ns/1ns
`default_nettype none
interface spdc_if;
   logic sclk;
   logic cs_n;
   logic sdio_host_o;
   logic sdio_host_oe;
   logic sdio_dev_o;
   logic sdio_dev_oe;
   logic sdio;
   assign sdio = sdio_host_oe ? sdio_host_o : (sdio_dev_oe ? sdio_dev_o : 1'b1);
   modport host (output sclk, output cs_n, output sdio_host_o, output sdio_host_oe,
                 input sdio);
   modport dev  (input sclk, input cs_n, input sdio, output sdio_dev_o,
                 output sdio_dev_oe);
endinterface : spdc_if
`default_nettype wire

/* File: hdl/spdc_device.sv */
// Device end: serial slave, buffered and active register banks, power and sync control.
`timescale 1ns/1ns
`default_nettype none
module spdc_device
   import spdc_pkg::*;
(
   // Clock and reset
   input  wire logic                      core_clk,
   input  wire logic                      reset,
   // Serial link
   spdc_if.dev                            link,
   // Multi-purpose pin and misalignment input
   input  wire logic                      multi_use_pin_n,
   input  wire logic [1:0]                misalign_halves,
   // Control outputs
   output logic                           sync_detect_en,
   output logic                           sync_window_narrow,
   output logic                           sync_flag,
   output logic                           dist_ref_pd,
   output logic                           sync_circuit_pd,
   output logic                           pll_pd,
   output logic                           dist_pd,
   output logic                           chip_reset,
   output logic [SPDC_NUM_OUT-1:0]        divider_pd,
   output logic [SPDC_NUM_OUT-1:0]        output_pd_safe,
   output logic [SPDC_NUM_OUT-1:0]        output_pd_off,
   output logic [SPDC_NUM_OUT-1:0]        sync_hold,
   output logic [SPDC_NUM_OUT-1:0]        sync_pulse,
   output logic                           fine_delay_a_pd,
   output logic                           fine_delay_b_pd
);
   import spdc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////////////////
   logic [7:0]                 buf_q [0:255];
   logic [7:0]                 act_sync_q;
   logic [7:0]                 act_pdn_q;
   logic [7:0]                 act_div_q [0:SPDC_NUM_OUT-1];
   logic                       sclk_q;
   logic [4:0]                 bitcnt_q;
   logic [15:0]                shift_q;
   logic [7:0]                 hdr_q;
   logic [7:0]                 rd_byte;
   logic                       commit_pend_q;
   logic                       soft_q;
   logic                       pin_q;
   logic                       rd_bit_q;
   logic                       rd_oe_q;
   logic                       sclk_rise;
   logic                       sclk_fall;
   logic                       frame_end;
   logic                       soft_fall;
   logic                       pin_rise;
   spdc_pin_mode_t             pin_mode;

   function automatic logic [7:0] rd_val(input logic [7:0] a, input logic [7:0] v);
      rd_val = (a == SPDC_ADDR_XFER || a == SPDC_ADDR_SPARE) ? 8'h00 : v;
   endfunction : rd_val

   assign sclk_rise = link.sclk & ~sclk_q & ~link.cs_n;
   assign sclk_fall = ~link.sclk & sclk_q & ~link.cs_n;
   assign frame_end = sclk_rise && bitcnt_q == 5'(SPDC_FRAME_BITS - 1);
   assign pin_mode  = spdc_pin_mode_t'(act_sync_q[SPDC_BIT_PIN_LO +: 2]);
   assign soft_fall = soft_q & ~act_sync_q[SPDC_BIT_SOFT_SYNC];
   assign pin_rise  = multi_use_pin_n & ~pin_q;
   assign link.sdio_dev_o  = rd_bit_q;
   assign link.sdio_dev_oe = rd_oe_q;
   assign rd_byte          = rd_val({1'b0, hdr_q[6:0]}, buf_q[{1'b0, hdr_q[6:0]}]);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Frame: bit 16 high means read, then 7 address bits, then 8 data bits, msb first.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         sclk_q   <= 1'b0;
         bitcnt_q <= SPDC_BITCNT_ZERO;
         shift_q  <= 16'h0000;
         hdr_q    <= 8'h00;
      end else begin
         sclk_q <= link.sclk;
         if (link.cs_n) begin
            bitcnt_q <= SPDC_BITCNT_ZERO;
         end else if (sclk_rise) begin
            // The header is kept apart because the data phase keeps shifting.
            if (bitcnt_q == 5'h07) begin
               hdr_q <= {shift_q[6:0], link.sdio};
            end
            shift_q  <= {shift_q[14:0], link.sdio};
            bitcnt_q <= frame_end ? SPDC_BITCNT_ZERO : bitcnt_q + 5'h01;
         end
      end
   end

   // Read data leaves on falling edges after the address, driven only in the data phase.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rd_bit_q <= 1'b0;
         rd_oe_q  <= 1'b0;
      end else if (link.cs_n) begin
         rd_oe_q <= 1'b0;
      end else if (sclk_fall && hdr_q[7] && bitcnt_q >= 5'h08 && bitcnt_q <= 5'h0f) begin
         rd_oe_q  <= 1'b1;
         rd_bit_q <= rd_byte[3'(5'h0f - bitcnt_q)];
      end else if (sclk_fall && bitcnt_q == 5'h10) begin
         rd_oe_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Buffered registers: writes land here and reach the logic only on a commit.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < 256; i++) begin
            buf_q[i] <= 8'h00;
         end
      end else if (frame_end && !shift_q[15]) begin
         buf_q[{1'b0, shift_q[14:8]}] <= shift_q[7:0];
      end
   end

   // A commit request waits for the next rising serial clock edge.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         commit_pend_q <= 1'b0;
      end else if (frame_end && !shift_q[15] && {1'b0, shift_q[14:8]} == SPDC_ADDR_XFER
                   && shift_q[SPDC_BIT_XFER]) begin
         commit_pend_q <= 1'b1;
      end else if (sclk_rise || (link.sclk & ~sclk_q)) begin
         commit_pend_q <= 1'b0;
      end
   end

   // Active registers change only by commit; power states never touch them.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         act_sync_q <= SPDC_SYNC_CTL_RST;
         act_pdn_q  <= SPDC_PDN_CTL_RST;
         for (int i = 0; i < SPDC_NUM_OUT; i++) begin
            act_div_q[i] <= SPDC_DIV_RST;
         end
      end else if (commit_pend_q && (link.sclk & ~sclk_q)) begin
         act_sync_q <= buf_q[SPDC_ADDR_SYNC_CTL];
         act_pdn_q  <= buf_q[SPDC_ADDR_PDN_CTL];
         for (int i = 0; i < SPDC_NUM_OUT; i++) begin
            act_div_q[i] <= buf_q[SPDC_ADDR_DIV_BASE + 8'(2 * i)];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Sync sources: soft bit falling edge, or pin rising edge in sync mode.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         soft_q <= 1'b0;
         pin_q  <= 1'b1;
      end else begin
         soft_q <= act_sync_q[SPDC_BIT_SOFT_SYNC];
         pin_q  <= multi_use_pin_n;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         sync_hold  <= '0;
         sync_pulse <= '0;
         chip_reset <= 1'b0;
      end else begin
         for (int i = 0; i < SPDC_NUM_OUT; i++) begin
            sync_hold[i] <= !act_div_q[i][SPDC_BIT_NOSYNC] && !act_sync_q[SPDC_BIT_SYNC_PD]
                            && (act_sync_q[SPDC_BIT_SOFT_SYNC]
                                || (pin_mode == SPDC_PIN_SYNC && !multi_use_pin_n));
            sync_pulse[i] <= !act_div_q[i][SPDC_BIT_NOSYNC] && !act_sync_q[SPDC_BIT_SYNC_PD]
                             && (soft_fall || (pin_mode == SPDC_PIN_SYNC && pin_rise));
         end
         chip_reset <= pin_mode == SPDC_PIN_RESET && !multi_use_pin_n;
      end
   end

   // Detect flag: window 1 flags half to one and a half cycles, window 0 flags one to one and a half.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         sync_detect_en     <= 1'b0;
         sync_window_narrow <= 1'b0;
         sync_flag          <= 1'b0;
      end else begin
         sync_detect_en     <= act_sync_q[SPDC_BIT_DET_EN];
         sync_window_narrow <= act_sync_q[SPDC_BIT_DET_WIN];
         sync_flag <= act_sync_q[SPDC_BIT_DET_EN] && !act_sync_q[SPDC_BIT_SYNC_PD]
                      && (act_sync_q[SPDC_BIT_DET_WIN] ? misalign_halves >= 2'd1
                                                       : misalign_halves >= 2'd2);
      end
   end

   // Power controls; the pin forces distribution off in power-down mode.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         dist_ref_pd     <= 1'b0;
         sync_circuit_pd <= 1'b0;
         pll_pd          <= 1'b0;
         dist_pd         <= 1'b0;
         divider_pd      <= '0;
         output_pd_safe  <= '0;
         output_pd_off   <= '0;
         fine_delay_a_pd <= 1'b1;
         fine_delay_b_pd <= 1'b1;
      end else begin
         dist_ref_pd     <= act_sync_q[SPDC_BIT_DIST_REF];
         sync_circuit_pd <= act_sync_q[SPDC_BIT_SYNC_PD];
         pll_pd          <= act_pdn_q[SPDC_BIT_PLL_PD];
         dist_pd         <= act_pdn_q[SPDC_BIT_DIST_PD]
                            || (pin_mode == SPDC_PIN_PDN && !multi_use_pin_n);
         for (int i = 0; i < SPDC_NUM_OUT; i++) begin
            divider_pd[i]     <= act_div_q[i][SPDC_BIT_BYPASS];
            output_pd_safe[i] <= act_div_q[i][SPDC_BIT_OUT_PD]
                                 && !act_div_q[i][SPDC_BIT_OUT_OFF];
            output_pd_off[i]  <= act_div_q[i][SPDC_BIT_OUT_PD]
                                 && act_div_q[i][SPDC_BIT_OUT_OFF];
         end
         fine_delay_a_pd <= !act_pdn_q[SPDC_BIT_FD_A_SEL];
         fine_delay_b_pd <= !act_pdn_q[SPDC_BIT_FD_B_SEL];
      end
   end
endmodule : spdc_device
`default_nettype wire

/* File: hdl/spdc_host.sv */
// Host end: serial master issuing one 17-bit register frame per accepted request.
`timescale 1ns/1ns
`default_nettype none
module spdc_host
   import spdc_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset,
   // Serial link
   spdc_if.host             link,
   // User request
   input  wire logic        req_valid,
   input  wire logic        req_read,
   input  wire logic [6:0]  req_addr,
   input  wire logic [7:0]  req_wdata,
   // User answer
   output logic             req_ready,
   output logic             rsp_valid,
   output logic [7:0]       rsp_rdata,
   output logic             req_refused
);
   import spdc_pkg::*;

   spdc_state_t  state_q;
   logic [15:0]  shift_q;
   logic [4:0]   bitcnt_q;
   logic         sclk_q;
   logic         cs_n_q;
   logic         rd_q;
   logic [7:0]   rx_q;

   assign link.sclk         = sclk_q;
   assign link.cs_n         = cs_n_q;
   assign link.sdio_host_o  = shift_q[15];
   assign link.sdio_host_oe = !cs_n_q && !(rd_q && bitcnt_q >= 5'h08);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Writing 10 to the pin role field is refused outright.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state_q     <= SPDC_ST_IDLE;
         shift_q     <= 16'h0000;
         bitcnt_q    <= SPDC_BITCNT_ZERO;
         sclk_q      <= 1'b0;
         cs_n_q      <= 1'b1;
         rd_q        <= 1'b0;
         rx_q        <= 8'h00;
         req_ready   <= 1'b0;
         rsp_valid   <= 1'b0;
         rsp_rdata   <= 8'h00;
         req_refused <= 1'b0;
      end else begin
         rsp_valid   <= 1'b0;
         req_refused <= 1'b0;
         unique case (state_q)
            SPDC_ST_IDLE: begin
               req_ready <= 1'b1;
               if (req_valid && req_ready) begin
                  req_ready <= 1'b0;
                  if (!req_read && {1'b0, req_addr} == SPDC_ADDR_SYNC_CTL
                      && req_wdata[SPDC_BIT_PIN_LO +: 2] == SPDC_PIN_TEST) begin
                     req_refused <= 1'b1;
                  end else begin
                     shift_q  <= {req_read, req_addr, req_wdata};
                     rd_q     <= req_read;
                     cs_n_q   <= 1'b0;
                     bitcnt_q <= SPDC_BITCNT_ZERO;
                     state_q  <= SPDC_ST_SHIFT;
                  end
               end
            end
            SPDC_ST_SHIFT: begin
               sclk_q <= ~sclk_q;
               if (sclk_q) begin
                  shift_q  <= {shift_q[14:0], 1'b0};
                  bitcnt_q <= bitcnt_q + 5'h01;
               end else if (bitcnt_q >= 5'h09) begin
                  rx_q <= {rx_q[6:0], link.sdio};
               end
               if (sclk_q && bitcnt_q == 5'(SPDC_FRAME_BITS - 1)) begin
                  state_q <= SPDC_ST_DONE;
               end
            end
            SPDC_ST_DONE: begin
               cs_n_q    <= 1'b1;
               rsp_valid <= 1'b1;
               rsp_rdata <= rd_q ? rx_q : 8'h00;
               state_q   <= SPDC_ST_IDLE;
            end
            default: state_q <= SPDC_ST_IDLE;
         endcase
      end
   end
endmodule : spdc_host
`default_nettype wire

/* File: verif/spdc_properties.sv */
// Concurrent checks on the serial link and the device control outputs.
`timescale 1ns/1ns
`default_nettype none
module spdc_properties
   import spdc_pkg::*;
(
   // Clock and reset
   input wire logic                    core_clk,
   input wire logic                    reset,
   // Link
   input wire logic                    sclk,
   input wire logic                    cs_n,
   input wire logic                    sdio_host_oe,
   input wire logic                    sdio_dev_oe,
   // Misalignment input and device outputs
   input wire logic [1:0]              misalign_halves,
   input wire logic                    sync_detect_en,
   input wire logic                    sync_flag,
   input wire logic                    sync_circuit_pd,
   input wire logic                    dist_ref_pd,
   input wire logic                    pll_pd,
   input wire logic                    dist_pd,
   input wire logic [SPDC_NUM_OUT-1:0] output_pd_safe,
   input wire logic [SPDC_NUM_OUT-1:0] output_pd_off
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////////////
   // The flag is registered, so a disable is given one cycle to take hold.
   flag_off_quiet_a: assert property (!sync_detect_en [*2] |-> !sync_flag)
      else $error("sync flag up while detection is off");
   aligned_no_flag_a: assert property ((sync_detect_en && misalign_halves == 2'h0) [*2]
      |-> !sync_flag)
      else $error("sync flag up with clocks aligned");
   wide_flag_up_a: assert property ((sync_detect_en && !sync_circuit_pd
      && misalign_halves == 2'h3) [*3] |-> sync_flag)
      else $error("sync flag missing at large misalignment");
   commit_in_frame_a: assert property ($changed({dist_ref_pd, sync_circuit_pd, pll_pd, dist_pd})
      |-> !$past(cs_n) || !$past(cs_n, 2) || !$past(cs_n, 3) || !$past(cs_n, 4))
      else $error("active control changed outside a frame");
   idle_link_a: assert property (cs_n |-> !sclk && !sdio_dev_oe)
      else $error("link not idle while deselected");
   one_driver_a: assert property (!(sdio_host_oe && sdio_dev_oe))
      else $error("both ends drive the data line");
   frame_min_a: assert property ($fell(cs_n) |-> !cs_n [*8])
      else $error("frame too short");
   frame_end_a: assert property ($fell(cs_n) |-> ##[30:40] cs_n)
      else $error("frame did not end in time");
   pd_state_excl_a: assert property ((output_pd_safe & output_pd_off) == '0)
      else $error("output both safe and off");
   pd_idle_hold_a: assert property (cs_n [*5] |-> $stable({pll_pd, dist_pd}))
      else $error("power-down moved without traffic");
   cover property ($rose(sync_flag));
   cover property ($fell(cs_n));
   cover property ($rose(|output_pd_off));
   cover property ($rose(dist_pd));
endmodule : spdc_properties
`default_nettype wire

/* File: verif/sync_and_powerdown_control_bench.sv */
// Self-checking bench joining the host and device ends over the serial link.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module sync_and_powerdown_control_bench;
   import spdc_pkg::*;
   logic                    core_clk = 1'b0;
   logic                    reset = 1'b1;
   logic                    req_valid = 1'b0;
   logic                    req_read = 1'b0;
   logic [6:0]              req_addr = 7'h00;
   logic [7:0]              req_wdata = 8'h00;
   logic                    multi_use_pin_n = 1'b1;
   logic [1:0]              misalign_halves = 2'h0;
   logic                    req_ready, rsp_valid, req_refused;
   logic [7:0]              rsp_rdata;
   logic                    sync_detect_en, sync_window_narrow, sync_flag, dist_ref_pd;
   logic                    sync_circuit_pd, pll_pd, dist_pd, chip_reset;
   logic                    fine_delay_a_pd, fine_delay_b_pd;
   logic [SPDC_NUM_OUT-1:0] divider_pd, output_pd_safe, output_pd_off, sync_hold, sync_pulse;
   logic [9:0]              exp_q[$];
   logic [9:0]              note;
   logic [7:0]              v, pv, b, d;
   logic [1:0]              m;
   logic [1:0]              modes[3] = '{2'b00, 2'b01, 2'b11};
   int                      n_errors = 0;
   int                      n_compared = 0;
   int                      k;
   int                      n_pulses = 0;
   spdc_if link();
   spdc_host u_spdc_host (.core_clk(core_clk), .reset(reset), .link(link),
      .req_valid(req_valid), .req_read(req_read), .req_addr(req_addr), .req_wdata(req_wdata),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .req_refused(req_refused));
   spdc_device u_spdc_device (.core_clk(core_clk), .reset(reset), .link(link),
      .multi_use_pin_n(multi_use_pin_n), .misalign_halves(misalign_halves),
      .sync_detect_en(sync_detect_en), .sync_window_narrow(sync_window_narrow),
      .sync_flag(sync_flag), .dist_ref_pd(dist_ref_pd), .sync_circuit_pd(sync_circuit_pd),
      .pll_pd(pll_pd), .dist_pd(dist_pd), .chip_reset(chip_reset), .divider_pd(divider_pd),
      .output_pd_safe(output_pd_safe), .output_pd_off(output_pd_off), .sync_hold(sync_hold),
      .sync_pulse(sync_pulse), .fine_delay_a_pd(fine_delay_a_pd),
      .fine_delay_b_pd(fine_delay_b_pd));
   spdc_properties u_spdc_properties (.core_clk(core_clk), .reset(reset), .sclk(link.sclk),
      .cs_n(link.cs_n), .sdio_host_oe(link.sdio_host_oe), .sdio_dev_oe(link.sdio_dev_oe),
      .misalign_halves(misalign_halves), .sync_detect_en(sync_detect_en),
      .sync_flag(sync_flag), .sync_circuit_pd(sync_circuit_pd), .dist_ref_pd(dist_ref_pd),
      .pll_pd(pll_pd), .dist_pd(dist_pd), .output_pd_safe(output_pd_safe),
      .output_pd_off(output_pd_off));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #25 core_clk = ~core_clk;
   end
   task end_sim;
      $display("compared=%0d errors=%0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_sim
   // Every request leaves a note: refused flag, read flag, expected read data.
   task automatic xfer(input logic rd, input logic [7:0] a, input logic [7:0] dat);
      int n;
      n = 0;
      exp_q.push_back({a == SPDC_ADDR_SYNC_CTL && !rd && dat[6:5] == 2'b10, rd, dat});
      @(posedge core_clk);
      req_valid <= 1'b1;
      req_read  <= rd;
      req_addr  <= a[6:0];
      req_wdata <= dat;
      do @(negedge core_clk); while (req_ready !== 1'b1 && ++n < 200);
      @(posedge core_clk);
      req_valid <= 1'b0;
      do @(negedge core_clk); while (rsp_valid !== 1'b1 && req_refused !== 1'b1 && ++n < 200);
      if (n >= 200) n_errors++;
   endtask : xfer
   // The commit lands on the sclk rise of the frame after the transfer write.
   task automatic commit;
      xfer(1'b0, SPDC_ADDR_XFER, 8'h01);
      xfer(1'b1, SPDC_ADDR_XFER, 8'h00);
   endtask : commit
   always @(negedge core_clk) begin
      if (rsp_valid === 1'b1 || req_refused === 1'b1) begin
         if (exp_q.size() == 0) begin
            n_errors++;
         end else begin
            note = exp_q.pop_front();
            `CHK(req_refused, note[9])
            if (note[8] && rsp_valid === 1'b1) `CHK(rsp_rdata, note[7:0])
         end
      end
   end
   always @(posedge core_clk) begin
      if (sync_pulse != '0) n_pulses <= n_pulses + 1;
   end
   initial begin
      #1000000;
      n_errors++;
      end_sim();
   end
   initial begin
      void'($urandom(32'he80f90fe));
      pv = 8'h00;
      repeat (20) @(posedge core_clk);
      reset <= 1'b0;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      `CHK({sync_detect_en, dist_ref_pd, pll_pd, divider_pd}, 11'h000)
      `CHK({fine_delay_a_pd, fine_delay_b_pd}, 2'b11)
      xfer(1'b1, SPDC_ADDR_SYNC_CTL, SPDC_SYNC_CTL_RST);
      $display("test reset_values done");
      for (int i = 0; i < 6; i++) begin
         v = (8'($urandom()) & 8'h1f) | {1'b0, modes[i % 3], 5'h00};
         m = 2'($urandom());
         @(posedge core_clk);
         misalign_halves <= m;
         xfer(1'b0, SPDC_ADDR_SYNC_CTL, v);
         `CHK({sync_detect_en, dist_ref_pd}, {pv[0], pv[3]})
         commit();
         xfer(1'b1, SPDC_ADDR_SYNC_CTL, v);
         `CHK({sync_detect_en, sync_window_narrow, dist_ref_pd, sync_circuit_pd}, {v[0], v[1], v[3], v[4]})
         if (!v[4]) `CHK(sync_flag, v[0] && (v[1] ? m != 2'h0 : m > 2'h1))
         if (!v[4] && v[6:5] != 2'b01) `CHK(sync_hold, {8{v[2]}})
         pv = v;
      end
      $display("test sync_control done");
      xfer(1'b0, SPDC_ADDR_SYNC_CTL, 8'h40);
      xfer(1'b1, SPDC_ADDR_SYNC_CTL, pv);
      xfer(1'b0, SPDC_ADDR_SPARE, 8'hff);
      xfer(1'b1, SPDC_ADDR_SPARE, 8'h00);
      $display("test refused_and_spare done");
      for (int i = 0; i < 4; i++) begin
         b = 8'($urandom()) & 8'h0f;
         d = 8'($urandom()) & 8'hf0;
         k = $urandom_range(SPDC_NUM_OUT - 1);
         xfer(1'b0, SPDC_ADDR_PDN_CTL, b);
         xfer(1'b0, SPDC_ADDR_DIV_BASE + 8'(2 * k), d);
         commit();
         `CHK({pll_pd, dist_pd, fine_delay_a_pd, fine_delay_b_pd}, {b[0], b[1], !b[2], !b[3]})
         `CHK({divider_pd[k], output_pd_safe[k], output_pd_off[k]}, {d[7], d[4] & !d[5], d[4] & d[5]})
         xfer(1'b1, SPDC_ADDR_SYNC_CTL, pv);
      end
      $display("test power_down done");
      // The host resynchronises after the power cycles with a soft sync.
      xfer(1'b0, SPDC_ADDR_SYNC_CTL, 8'h04);
      commit();
      k = n_pulses;
      xfer(1'b0, SPDC_ADDR_SYNC_CTL, 8'h00);
      commit();
      `CHK(n_pulses > k, 1'b1)
      @(posedge core_clk);
      multi_use_pin_n <= 1'b0;
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      `CHK(chip_reset, 1'b1)
      @(posedge core_clk);
      multi_use_pin_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      `CHK(chip_reset, 1'b0)
      `CHK(exp_q.size(), 0)
      $display("test pin_reset done");
      end_sim();
   end
endmodule : sync_and_powerdown_control_bench
`default_nettype wire
